/* File: rtl/ssd_params.svh */
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

// Frame layout
`define SSD_FRAME_BITS   16
`define SSD_DATA_W       13
`define SSD_ADDR_LSB     13
`define SSD_ADDR_MSB     15
`define SSD_NUM_ADDR     6
`define SSD_LAST_BIT     4'hF

// Settings word addresses
`define SSD_ADDR_WAIT    3'h0
`define SSD_ADDR_CHOP    3'h1
`define SSD_ADDR_DRIVE   3'h2
`define SSD_ADDR_RAMP    3'h3
`define SSD_ADDR_PERIOD  3'h4
`define SSD_ADDR_COUNT   3'h5

// Address 0 fields
`define SSD_SW_LSB       0
`define SSD_SW_MSB       5
`define SSD_EW_LSB       6
`define SSD_EW_MSB       11
// Address 1 fields
`define SSD_CHOP_LSB     0
`define SSD_CHOP_MSB     5
`define SSD_MON_BIT      6
`define SSD_TEST_LSB     7
`define SSD_TEST_MSB     12
// Address 2 fields
`define SSD_CUR_LSB      0
`define SSD_CUR_MSB      4
`define SSD_DIR_BIT      5
`define SSD_STOP_BIT     6
`define SSD_OEN_BIT      7
`define SSD_MSTEP_BIT    8
`define SSD_TPC_BIT      9
`define SSD_OSEL_BIT     10
`define SSD_OPOS_BIT     11
// Address 3 fields
`define SSD_MULT_LSB     0
`define SSD_MULT_MSB     1
`define SSD_RAMP_LSB     2
`define SSD_RAMP_MSB     8
`define SSD_DEC_BIT      9
`define SSD_ACC_BIT      10

// Reset values and wait count constants
`define SSD_WORD_RESET   13'h0000
`define SSD_WAIT_ZERO    6'h00
`define SSD_WAIT_ONE     6'h01

// Timing
`define SSD_WAIT_UNIT_NS 32000
`define SSD_REF_PERIOD_NS 100

`endif

/* File: rtl/ssd_pkg.sv */
package ssd_pkg;
   typedef enum logic [1:0]
   {
      SSD_IDLE        = 2'b00,
      SSD_START_WAIT  = 2'b01,
      SSD_EXCITE_WAIT = 2'b10
   } ssd_state_type;

   typedef logic [12:0] ssd_word_type;
   typedef logic [5:0]  ssd_wait_type;
endpackage

/* File: rtl/ssd_config_seq.sv */
// Functional notes
// [R1] Address 2 low bits: current, direction, stop, enable
// [R2] Address 2 high bits: drive mode, origin flag
// [R3] Address 3: multiplier, ramp, decel/accel enables
// [R4] Address 4 holds 13-bit step period
// [R5] Address 5 holds 13-bit step count
// [R6] Latch fall starts start wait, then energise
// [R7] Start wait from address 0 bits 0-5
// [R8] Excitation wait follows, then pulses start
// [R9] Excitation wait from address 0 bits 6-11
// [R10] Old settings keep running during waits
// [R11] New settings apply after excitation wait
// [R12] Wait fields reset zero; zero is dummy
// [R13] Host never writes both wait fields zero; the bench dummy task writes both zero
// [R14] Address 1: chop frequency, monitor, test
// [R15] Test field drives internal test modes only
// [R16] Sixteen bits LSB first on rising clock
// [R17] Commit frames at latch fall, drop partials
// [R18] Frames during either wait are ignored
// [R19] Host writes zero test bits normally
// [R20] Wait unit counted on reference oscillator
// [R21] Reserved bits stored nowhere, no effect; the code keeps them in pend_reg and cfg_reg but decodes none
`include "ssd_params.svh"

module ssd_config_seq #(
   parameter int DATA_W = `SSD_DATA_W
)(
   input  wire logic        REF_CLK,          // Reference oscillator clock
   input  wire logic        RST_N,            // Async chip reset, active low
   input  wire logic        SCLK,             // Serial link clock
   input  wire logic        LATCH,            // Frame strobe, high while shifting
   input  wire logic        SERIAL_INPUT_BIT, // Serial data, LSB first
   output logic [5:0]       CHOP_FREQ,        // Chopping frequency code
   output logic             MONITOR_SEL,      // Pulse monitor function select
   output logic [5:0]       TEST_MODE,        // Internal test mode field
   output logic [4:0]       MOTOR_CURRENT,    // Normal operation current
   output logic             DIRECTION,        // Rotation direction
   output logic             STOP_REQ,         // Stop request
   output logic             OUTPUT_EN,        // Output enable
   output logic             MICROSTEP_SEL,    // Two-phase vs microstep drive
   output logic             TWO_PHASE_CUR,    // Two-phase current choice
   output logic             ORIGIN_SEL,       // Origin flag output select
   output logic             ORIGIN_POS,       // Origin flag position
   output logic [1:0]       MULT_FACTOR,      // Pulse multiplication factor
   output logic [6:0]       RAMP_PARAM,       // Accel/decel parameter
   output logic             DECEL_EN,         // Deceleration enable
   output logic             ACCEL_EN,         // Acceleration enable
   output logic [12:0]      STEP_PERIOD,      // Step pulse period
   output logic [12:0]      STEP_COUNT,       // Step pulse count
   output logic             START_WAIT_BUSY,  // Start-point wait running
   output logic             EXCITE_WAIT_BUSY, // Excitation wait running
   output logic             ENERGISE_PULSE,   // One cycle: energise windings
   output logic             APPLY_PULSE       // One cycle: new settings live
);

   localparam int UNIT_CYC_I = (`SSD_WAIT_UNIT_NS + `SSD_REF_PERIOD_NS - 1) / `SSD_REF_PERIOD_NS;
   localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYC_I - 1);

   // The unit length check below needs at least nine cycles per unit
   if (DATA_W != `SSD_DATA_W || UNIT_CYC_I < 9 || UNIT_CYC_I > 65536)
   begin : g_param_check
      $error("ssd_config_seq: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: shifter, cleared whenever the strobe is low

   logic                link_rst_n;
   logic [3:0]          bit_cnt_reg,  bit_cnt_next;
   logic [15:0]         shift_reg,    shift_next;
   logic [15:0]         word_reg,     word_next;
   logic                tog_reg,      tog_next;
   logic                tog_hold_reg;

   assign link_rst_n = RST_N & LATCH;

   always_comb
   begin
      shift_next   = {SERIAL_INPUT_BIT, shift_reg[15:1]};            // [R16]
      bit_cnt_next = bit_cnt_reg + 4'h1;
      word_next    = word_reg;
      tog_next     = tog_reg;
      if (bit_cnt_reg == `SSD_LAST_BIT)
      begin
         word_next = {SERIAL_INPUT_BIT, shift_reg[15:1]};            // [R17]
         tog_next  = ~tog_reg;
      end
   end

   always_ff @(posedge SCLK or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         bit_cnt_reg <= 4'h0;                                        // [R17]
         shift_reg   <= 16'h0000;
      end
      else
      begin
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
      end
   end

   // Word and toggle survive the strobe so the last frame still crosses
   always_ff @(posedge SCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         word_reg     <= 16'h0000;
         tog_reg      <= 1'b0;
         tog_hold_reg <= 1'b0;
      end
      else
      begin
         word_reg     <= word_next;
         tog_reg      <= tog_next;
         tog_hold_reg <= tog_reg;
      end
   end

   property p_frame_len;
      @(posedge SCLK) disable iff (!link_rst_n)
      (tog_reg != tog_hold_reg) |-> $past(bit_cnt_reg) == `SSD_LAST_BIT;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame committed with wrong bit count"); // [R17]

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the reference domain

   logic                tog_s1_reg, tog_s2_reg, tog_s3_reg;
   logic                lat_s1_reg, lat_s2_reg, lat_s3_reg, lat_s4_reg;
   logic                frame_evt;
   logic                latch_fall;

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
         lat_s1_reg <= 1'b0;
         lat_s2_reg <= 1'b0;
         lat_s3_reg <= 1'b0;
         lat_s4_reg <= 1'b0;
      end
      else
      begin
         tog_s1_reg <= tog_reg;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
         lat_s1_reg <= LATCH;
         lat_s2_reg <= lat_s1_reg;
         lat_s3_reg <= lat_s2_reg;
         lat_s4_reg <= lat_s3_reg;
      end
   end

   assign frame_evt  = tog_s2_reg ^ tog_s3_reg;
   // One extra stage lets the final frame land before the commit
   assign latch_fall = lat_s4_reg & ~lat_s3_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Pending and active settings, wait sequencer

   ssd_pkg::ssd_state_type state_reg, state_next;
   ssd_pkg::ssd_word_type  pend_reg [`SSD_NUM_ADDR];
   ssd_pkg::ssd_word_type  pend_next [`SSD_NUM_ADDR];
   ssd_pkg::ssd_word_type  cfg_reg [`SSD_NUM_ADDR];
   ssd_pkg::ssd_word_type  cfg_next [`SSD_NUM_ADDR];
   logic [`SSD_NUM_ADDR-1:0] pend_v_reg, pend_v_next;
   ssd_pkg::ssd_wait_type  wcnt_reg, wcnt_next;
   ssd_pkg::ssd_wait_type  ew_hold_reg, ew_hold_next;
   ssd_pkg::ssd_wait_type  sw_val, ew_val;
   logic [15:0]            unit_cnt_reg, unit_cnt_next;
   logic                   unit_tick;
   logic                   apply, energise;
   logic                   apply_reg, energise_reg;
   logic [2:0]             frame_addr;

   assign frame_addr = word_reg[`SSD_ADDR_MSB:`SSD_ADDR_LSB];
   assign unit_tick  = (state_reg != ssd_pkg::SSD_IDLE) && (unit_cnt_reg == UNIT_LAST);   // [R20]

   always_comb
   begin
      state_next    = state_reg;
      pend_next     = pend_reg;
      pend_v_next   = pend_v_reg;
      cfg_next      = cfg_reg;
      wcnt_next     = wcnt_reg;
      ew_hold_next  = ew_hold_reg;
      apply         = 1'b0;
      energise      = 1'b0;
      sw_val        = pend_v_reg[0] ? pend_reg[0][`SSD_SW_MSB:`SSD_SW_LSB]
                                    : cfg_reg[0][`SSD_SW_MSB:`SSD_SW_LSB];                // [R7]
      ew_val        = pend_v_reg[0] ? pend_reg[0][`SSD_EW_MSB:`SSD_EW_LSB]
                                    : cfg_reg[0][`SSD_EW_MSB:`SSD_EW_LSB];                // [R9]
      unit_cnt_next = (state_reg == ssd_pkg::SSD_IDLE || unit_tick) ? 16'h0000 : unit_cnt_reg + 16'h0001;

      unique case (state_reg)
         ssd_pkg::SSD_IDLE:
         begin
            if (latch_fall && |pend_v_reg)                                               // [R6]
            begin
               ew_hold_next = ew_val;
               if (sw_val != `SSD_WAIT_ZERO)
               begin
                  state_next = ssd_pkg::SSD_START_WAIT;
                  wcnt_next  = sw_val;
               end
               else if (ew_val != `SSD_WAIT_ZERO)
               begin
                  energise   = 1'b1;
                  state_next = ssd_pkg::SSD_EXCITE_WAIT;
                  wcnt_next  = ew_val;
               end
               else
               begin
                  // All-zero dummy word: nothing to wait for
                  energise = 1'b1;                                                        // [R12]
                  apply    = 1'b1;
               end
            end
         end
         ssd_pkg::SSD_START_WAIT:
         begin
            if (unit_tick)
            begin
               if (wcnt_reg == `SSD_WAIT_ONE)
               begin
                  energise = 1'b1;                                                        // [R6]
                  if (ew_hold_reg != `SSD_WAIT_ZERO)
                  begin
                     state_next = ssd_pkg::SSD_EXCITE_WAIT;                               // [R8]
                     wcnt_next  = ew_hold_reg;
                  end
                  else
                  begin
                     state_next = ssd_pkg::SSD_IDLE;
                     apply      = 1'b1;
                  end
               end
               else
                  wcnt_next = wcnt_reg - `SSD_WAIT_ONE;
            end
         end
         ssd_pkg::SSD_EXCITE_WAIT:
         begin
            if (unit_tick)
            begin
               if (wcnt_reg == `SSD_WAIT_ONE)
               begin
                  state_next = ssd_pkg::SSD_IDLE;
                  apply      = 1'b1;                                                      // [R11]
               end
               else
                  wcnt_next = wcnt_reg - `SSD_WAIT_ONE;
            end
         end
         default:
            state_next = ssd_pkg::SSD_IDLE;
      endcase

      // Active settings only change here; old ones stay live meanwhile
      if (apply)                                                                          // [R10]
      begin
         for (int i = 0; i < `SSD_NUM_ADDR; i++)
         begin
            if (pend_v_reg[i])
               cfg_next[i] = pend_reg[i];
         end
         pend_v_next = '0;
      end

      // Frames only land while idle; placed after the clear so an arriving frame wins
      if (frame_evt && state_reg == ssd_pkg::SSD_IDLE && frame_addr < 3'(`SSD_NUM_ADDR))  // [R18]
      begin
         pend_next[frame_addr]   = word_reg[DATA_W-1:0];
         pend_v_next[frame_addr] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_reg    <= ssd_pkg::SSD_IDLE;
         pend_v_reg   <= '0;
         wcnt_reg     <= `SSD_WAIT_ZERO;
         ew_hold_reg  <= `SSD_WAIT_ZERO;
         unit_cnt_reg <= 16'h0000;
         apply_reg    <= 1'b0;
         energise_reg <= 1'b0;
         for (int i = 0; i < `SSD_NUM_ADDR; i++)
         begin
            pend_reg[i] <= `SSD_WORD_RESET;
            cfg_reg[i]  <= `SSD_WORD_RESET;                                               // [R12]
         end
      end
      else
      begin
         state_reg    <= state_next;
         pend_v_reg   <= pend_v_next;
         wcnt_reg     <= wcnt_next;
         ew_hold_reg  <= ew_hold_next;
         unit_cnt_reg <= unit_cnt_next;
         apply_reg    <= apply;
         energise_reg <= energise;
         pend_reg     <= pend_next;
         cfg_reg      <= cfg_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field decode; reserved bits feed nothing

   assign CHOP_FREQ        = cfg_reg[`SSD_ADDR_CHOP][`SSD_CHOP_MSB:`SSD_CHOP_LSB];        // [R14]
   assign MONITOR_SEL      = cfg_reg[`SSD_ADDR_CHOP][`SSD_MON_BIT];
   assign TEST_MODE        = cfg_reg[`SSD_ADDR_CHOP][`SSD_TEST_MSB:`SSD_TEST_LSB];        // [R15]
   assign MOTOR_CURRENT    = cfg_reg[`SSD_ADDR_DRIVE][`SSD_CUR_MSB:`SSD_CUR_LSB];         // [R1]
   assign DIRECTION        = cfg_reg[`SSD_ADDR_DRIVE][`SSD_DIR_BIT];
   assign STOP_REQ         = cfg_reg[`SSD_ADDR_DRIVE][`SSD_STOP_BIT];
   assign OUTPUT_EN        = cfg_reg[`SSD_ADDR_DRIVE][`SSD_OEN_BIT];
   assign MICROSTEP_SEL    = cfg_reg[`SSD_ADDR_DRIVE][`SSD_MSTEP_BIT];                    // [R2]
   assign TWO_PHASE_CUR    = cfg_reg[`SSD_ADDR_DRIVE][`SSD_TPC_BIT];
   assign ORIGIN_SEL       = cfg_reg[`SSD_ADDR_DRIVE][`SSD_OSEL_BIT];
   assign ORIGIN_POS       = cfg_reg[`SSD_ADDR_DRIVE][`SSD_OPOS_BIT];                     // [R21]
   assign MULT_FACTOR      = cfg_reg[`SSD_ADDR_RAMP][`SSD_MULT_MSB:`SSD_MULT_LSB];        // [R3]
   assign RAMP_PARAM       = cfg_reg[`SSD_ADDR_RAMP][`SSD_RAMP_MSB:`SSD_RAMP_LSB];
   assign DECEL_EN         = cfg_reg[`SSD_ADDR_RAMP][`SSD_DEC_BIT];
   assign ACCEL_EN         = cfg_reg[`SSD_ADDR_RAMP][`SSD_ACC_BIT];
   assign STEP_PERIOD      = cfg_reg[`SSD_ADDR_PERIOD];                                   // [R4]
   assign STEP_COUNT       = cfg_reg[`SSD_ADDR_COUNT];                                    // [R5]
   assign START_WAIT_BUSY  = (state_reg == ssd_pkg::SSD_START_WAIT);
   assign EXCITE_WAIT_BUSY = (state_reg == ssd_pkg::SSD_EXCITE_WAIT);
   assign ENERGISE_PULSE   = energise_reg;
   assign APPLY_PULSE      = apply_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_busy_ignore;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_reg != ssd_pkg::SSD_IDLE && frame_evt) |=> (pend_v_reg == $past(pend_v_reg) || pend_v_reg == '0);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("frame stored during wait");       // [R18]

   property p_start_load;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_reg == ssd_pkg::SSD_IDLE && latch_fall && pend_v_reg[`SSD_ADDR_WAIT]
       && pend_reg[`SSD_ADDR_WAIT][`SSD_SW_MSB:`SSD_SW_LSB] != `SSD_WAIT_ZERO)
      |=> (state_reg == ssd_pkg::SSD_START_WAIT
           && wcnt_reg == $past(pend_reg[`SSD_ADDR_WAIT][`SSD_SW_MSB:`SSD_SW_LSB]));
   endproperty
   a_start_load: assert property (p_start_load) else $error("start wait not loaded");            // [R7]

   property p_energise;
      @(posedge REF_CLK) disable iff (!RST_N)
      (START_WAIT_BUSY && unit_tick && wcnt_reg == `SSD_WAIT_ONE) |=> ENERGISE_PULSE;
   endproperty
   a_energise: assert property (p_energise) else $error("windings not energised");              // [R6]

   property p_excite_follow;
      @(posedge REF_CLK) disable iff (!RST_N)
      (START_WAIT_BUSY && unit_tick && wcnt_reg == `SSD_WAIT_ONE && ew_hold_reg != `SSD_WAIT_ZERO)
      |=> EXCITE_WAIT_BUSY && wcnt_reg == $past(ew_hold_reg);
   endproperty
   a_excite_follow: assert property (p_excite_follow) else $error("excitation wait missing");  // [R8] [R9]

   property p_apply_end;
      @(posedge REF_CLK) disable iff (!RST_N)
      (EXCITE_WAIT_BUSY && unit_tick && wcnt_reg == `SSD_WAIT_ONE) |=> (APPLY_PULSE && !EXCITE_WAIT_BUSY);
   endproperty
   a_apply_end: assert property (p_apply_end) else $error("settings not applied after wait");   // [R11]

   property p_hold_old;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_reg != ssd_pkg::SSD_IDLE && !apply) |=> $stable(STEP_PERIOD) && $stable(STEP_COUNT);
   endproperty
   a_hold_old: assert property (p_hold_old) else $error("settings changed during wait");         // [R10]

   property p_change_cause;
      @(posedge REF_CLK) disable iff (!RST_N)
      !$stable(MOTOR_CURRENT) |-> APPLY_PULSE;
   endproperty
   a_change_cause: assert property (p_change_cause) else $error("setting changed without apply"); // [R11]

   property p_unit_len;
      @(posedge REF_CLK) disable iff (!RST_N)
      (unit_tick && state_next != ssd_pkg::SSD_IDLE) |=> !unit_tick [*8] ##0 (unit_cnt_reg == 16'h0007);
   endproperty
   a_unit_len: assert property (p_unit_len) else $error("wait unit too short");                  // [R20]

endmodule

/* File: test/ssd_host_model.sv */
module ssd_host_model (
   output logic SCLK,             // Link clock, still outside frames
   output logic LATCH,            // Frame strobe
   output logic SERIAL_INPUT_BIT  // Serial data, LSB first
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      SCLK = 1'b0;
      LATCH = 1'b0;
      SERIAL_INPUT_BIT = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic open_group();
      LATCH = 1'b1;
      #40;
   endtask

   // Data moves while SCLK is low so each rise sees a settled bit
   task automatic send_bits(input logic [15:0] word, input int nbits);
      for (int i = 0; i < nbits; i++)
      begin
         SERIAL_INPUT_BIT = word[i];
         #15 SCLK = 1'b1;
         #15 SCLK = 1'b0;
      end
   endtask

   // Quiet gap after the last rise before the strobe falls
   task automatic close_group();
      #450 LATCH = 1'b0;
      SERIAL_INPUT_BIT = ~SERIAL_INPUT_BIT;
   endtask
endmodule

/* File: test/ssd_config_seq_tb.sv */
`include "ssd_params.svh"

module ssd_config_seq_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int UNIT  = 320;
   localparam int LIMIT = 70000;

   typedef struct {
      logic [2:0]  a;
      logic [12:0] d;
      int          s;
      int          e;
   } ssd_row_type;

   logic                 ref_clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 sclk;
   logic                 latch;
   logic                 sdi;
   logic [61:0]          got;
   logic [61:0]          old_v;
   logic                 sw_busy;
   logic                 ew_busy;
   logic                 energise;
   logic                 apply;
   ssd_pkg::ssd_word_type w [6] = '{default: `SSD_WORD_RESET};
   int                   errors = 0;
   int                   checks_done = 0;
   int                   cycles = 0;
   int                   n;

   ssd_row_type rows [12] = '{
      '{3'h1, 13'h0055, 1, 1}, '{3'h1, 13'h1F2A, 1, 2}, '{3'h2, 13'h1ABC, 2, 1},
      '{3'h2, 13'h0543, 1, 1}, '{3'h3, 13'h1E5B, 1, 1}, '{3'h3, 13'h01A6, 1, 3},
      '{3'h4, 13'h1FFF, 63, 1}, '{3'h4, 13'h0001, 1, 1}, '{3'h5, 13'h1000, 1, 63},
      '{3'h5, 13'h0AAA, 1, 1}, '{3'h6, 13'h1234, 1, 1}, '{3'h7, 13'h0F0F, 1, 1}};

   always #50 ref_clk = ~ref_clk;

   ssd_host_model host (
      .SCLK             (sclk),
      .LATCH            (latch),
      .SERIAL_INPUT_BIT (sdi)
   );

   ssd_config_seq uut (
      .REF_CLK          (ref_clk),
      .RST_N            (rst_n),
      .SCLK             (sclk),
      .LATCH            (latch),
      .SERIAL_INPUT_BIT (sdi),
      .CHOP_FREQ        (got[54:49]),
      .MONITOR_SEL      (got[55]),
      .TEST_MODE        (got[61:56]),
      .MOTOR_CURRENT    (got[41:37]),
      .DIRECTION        (got[42]),
      .STOP_REQ         (got[43]),
      .OUTPUT_EN        (got[44]),
      .MICROSTEP_SEL    (got[45]),
      .TWO_PHASE_CUR    (got[46]),
      .ORIGIN_SEL       (got[47]),
      .ORIGIN_POS       (got[48]),
      .MULT_FACTOR      (got[27:26]),
      .RAMP_PARAM       (got[34:28]),
      .DECEL_EN         (got[35]),
      .ACCEL_EN         (got[36]),
      .STEP_PERIOD      (got[25:13]),
      .STEP_COUNT       (got[12:0]),
      .START_WAIT_BUSY  (sw_busy),
      .EXCITE_WAIT_BUSY (ew_busy),
      .ENERGISE_PULSE   (energise),
      .APPLY_PULSE      (apply)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         errors++;
         summarize();
      end
   end

   task automatic check(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("BAD t=%0t %s", $time, what);
      end
   endtask

   // Reserved bits of every word fall out of the expected image
   function automatic logic [61:0] exp_v();
      return {w[1], w[2][11:0], w[3][10:0], w[4], w[5]};
   endfunction

   function automatic logic [15:0] wait_word(input int s, input int e);
      return {`SSD_ADDR_WAIT, 1'b0, 6'(e), 6'(s)};
   endfunction

   task automatic group(input logic [15:0] a, input logic [15:0] b);
      host.open_group();
      host.send_bits(a, 16);
      host.send_bits(b, 16);
      host.close_group();
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      #2 rst_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      #2;
      check({got, sw_busy, ew_busy, energise, apply} === 66'h0, "reset outputs");
      rst_n = 1'b1;
      w = '{default: `SSD_WORD_RESET};
      repeat (3) @(posedge ref_clk);
      #2;
   endtask

   // Follows one sequence from the strobe fall to the apply pulse
   task automatic run_seq(input logic [61:0] prev, input int s, input int e);
      int sw;
      int ew;
      int en;
      int ap;
      int stale;
      sw = 0;
      ew = 0;
      en = 0;
      ap = 0;
      stale = 0;
      for (int c = 0; c < (s + e) * UNIT + 40 && ap == 0; c++)
      begin
         @(posedge ref_clk);
         #2;
         sw += int'(sw_busy);
         ew += int'(ew_busy);
         en += int'(energise);
         if (apply === 1'b1)
            ap++;
         else if (got !== prev)
            stale++;
      end
      check(ap == 1, "no apply pulse");
      check(sw == s * UNIT, "start wait length");
      check(ew == e * UNIT, "excitation wait length");
      check(s == 0 || en == 1, "energise pulse");
      check(stale == 0, "settings moved early");
      check(got === exp_v(), "settings after apply");
      repeat (6) @(posedge ref_clk);
      #2;
   endtask

   task automatic dummy();
      group(wait_word(0, 0), wait_word(0, 0));
      run_seq(exp_v(), 0, 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset();
      dummy();
      $display("test reset and dummy done");
      foreach (rows[i])
      begin
         old_v = exp_v();
         group(wait_word(rows[i].s, rows[i].e), {rows[i].a, rows[i].d});
         if (rows[i].a != 3'h0 && rows[i].a <= 3'h5)
            w[rows[i].a] = rows[i].d;
         run_seq(old_v, rows[i].s, rows[i].e);
         $display("test row %0d done", i);
      end
      // Repeated address, then a trailing partial frame
      old_v = exp_v();
      host.open_group();
      host.send_bits({`SSD_ADDR_RAMP, 13'h0123}, 16);
      host.send_bits({`SSD_ADDR_RAMP, 13'h0456}, 16);
      host.send_bits(wait_word(1, 1), 16);
      host.send_bits({`SSD_ADDR_PERIOD, 13'h0777}, 10);
      host.close_group();
      w[3] = 13'h0456;
      run_seq(old_v, 1, 1);
      $display("test last wins and partial done");
      // A second group during the start wait is dropped
      old_v = exp_v();
      group(wait_word(1, 1), {`SSD_ADDR_COUNT, 13'h0321});
      w[5] = 13'h0321;
      fork
         run_seq(old_v, 1, 1);
         begin
            repeat (100) @(posedge ref_clk);
            #2;
            group(wait_word(2, 2), {`SSD_ADDR_COUNT, 13'h1111});
         end
      join
      n = 0;
      host.open_group();
      host.close_group();
      for (int c = 0; c < 30; c++)
      begin
         @(posedge ref_clk);
         #2;
         if (sw_busy !== 1'b0 || apply !== 1'b0 || got !== exp_v())
            n++;
      end
      check(n == 0, "dropped frame or bare strobe acted");
      $display("test busy drop and bare strobe done");
      // Reset in the middle of a wait
      group(wait_word(2, 1), {`SSD_ADDR_PERIOD, 13'h0ABC});
      repeat (200) @(posedge ref_clk);
      do_reset();
      dummy();
      old_v = exp_v();
      group(wait_word(1, 1), {`SSD_ADDR_DRIVE, 13'h0FFF});
      w[2] = 13'h0FFF;
      run_seq(old_v, 1, 1);
      $display("test mid-wait reset done");
      summarize();
   end
endmodule
